// >>> design/cants_pkg.sv
// shared constants for the can test-mode, time stamp and sleep controller
package cants_pkg;
	// clock and link timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned BITRATE_BPS = 500_000;

	// apb map
	localparam int unsigned APB_AW = 8;
	localparam int unsigned APB_DW = 32;
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_TX = 8'h08;
	localparam logic [7:0] OFS_TSTAMP = 8'h0c;
	localparam logic [7:0] OFS_MBID = 8'h10;
	localparam logic [7:0] OFS_MBDATA = 8'h20;

	// operating modes as written to the mode register
	localparam int unsigned MODE_W = 3;
	localparam logic [2:0] MODE_SLEEP = 3'h0;
	localparam logic [2:0] MODE_NORMAL = 3'h1;
	localparam logic [2:0] MODE_INTLB = 3'h2;
	localparam logic [2:0] MODE_EXTLB = 3'h3;
	localparam logic [2:0] MODE_LISTEN = 3'h4;
	localparam logic [2:0] MODE_RESET = MODE_SLEEP;

	// field layout
	localparam int unsigned ID_W = 11;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned TS_W = 16;
	localparam int unsigned FRAME_W = ID_W + DATA_W;
	localparam int unsigned TX_ID_LSB = 8;
	localparam int unsigned MB_EN_BIT = 31;
	localparam int unsigned MBD_TS_LSB = 16;
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_ACKERR = 1;
	localparam int unsigned ST_FULL = 2;
	localparam int unsigned ST_EMPTY = 3;
	localparam int unsigned ST_NEW_LSB = 4;

	// mailboxes and tx queue
	localparam int unsigned MB_N = 4;
	localparam int unsigned MB_AW = 2;
	localparam int unsigned TXQ_DEPTH = 8;

	// bit positions inside a frame
	localparam int unsigned POS_W = 5;
	localparam logic [4:0] POS_SOF = 5'h00;
	localparam logic [4:0] POS_ID0 = 5'h01;
	localparam logic [4:0] POS_ACK = 5'h14;
	localparam logic [4:0] POS_LAST = 5'h1b;
	localparam logic [4:0] ERR_LAST = 5'h05;

	typedef enum logic [1:0] {ENG_IDLE, ENG_FRAME, ENG_ERROR} cants_eng_t;
endpackage

// >>> design/cants_fifo.sv
// transmit queue between the register port and the bit engine
module cants_fifo #(
	parameter int unsigned WIDTH = 19,
	parameter int unsigned DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic push, pop;

	assign in_ready = (cnt_ff != CNT_FULL);
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem_ff[rd_ff];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		nxt_wr = wr_ff;
		nxt_rd = rd_ff;
		nxt_cnt = cnt_ff;
		if (push) begin
			nxt_wr = (wr_ff == PTR_LAST) ? '0 : wr_ff + 1'b1;
		end
		if (pop) begin
			nxt_rd = (rd_ff == PTR_LAST) ? '0 : rd_ff + 1'b1;
		end
		if (push && !pop) begin
			nxt_cnt = cnt_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end

	// storage has no reset: only words between the read and write pointers are ever used
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end
endmodule

// >>> design/cants_mbmem.sv
// receive mailbox store: one write port, one registered read port
module cants_mbmem #(
	parameter int unsigned AW = 2,
	parameter int unsigned W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// read port
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem_ff [2**AW];
	logic [W-1:0] rdata_ff, nxt_rdata;

	assign rdata = rdata_ff;

	always_comb begin
		nxt_rdata = re ? mem_ff[raddr] : rdata_ff;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem_ff[waddr] <= wdata;
		end
	end
endmodule

// >>> design/cants_ctrl.sv
// can controller core: operating modes, loopback, listen-only, time stamps, sleep
//
// How it works
// - in either loopback a sent frame also enters the own receive path
// - internal loopback keeps the pin recessive and feeds transmit back internally
// - internal loopback drives its own acknowledge slot dominant
// - own frames are stored in matching mailboxes only in loopback modes
// - internal loopback never sees acknowledge errors, so no error frames
// - external loopback drives the frame onto the pin and receives it too
// - external loopback acknowledges its own frame on the bus
// - listen-only never drives acknowledge or error frames, still receives
// - a stored frame captures the time stamp counter in its mailbox
// - reset leaves the controller asleep until software picks another mode
// - sleep drops the module clock enable at once and freezes the bit engine and time stamp counter; the register port and tx queue stay live
// - entering sleep clears or reinitialises no register
module cants_ctrl
	import cants_pkg::*;
#(
	parameter int unsigned BITRATE = cants_pkg::BITRATE_BPS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic [cants_pkg::APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cants_pkg::APB_DW-1:0] pwdata,
	output logic [cants_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// can pins, 0 is dominant
	input wire logic can_rx,
	output logic can_tx,
	// enable for the module clock gate
	output logic module_clk_en
);
	import cants_pkg::*;

	localparam int unsigned BIT_CYC = CLK_HZ / BITRATE;
	localparam int unsigned BCW = $clog2(BIT_CYC + 1);
	localparam logic [BCW-1:0] BIT_LAST = BCW'(BIT_CYC - 1);
	localparam logic [BCW-1:0] SAMPLE_PT = BCW'(BIT_CYC / 2);

	function automatic logic is_loopback(input logic [MODE_W-1:0] m);
		return (m == MODE_INTLB) || (m == MODE_EXTLB);
	endfunction

	function automatic logic in_block(input logic [APB_AW-1:0] a, input logic [7:0] base);
		return a[APB_AW-1:4] == base[APB_AW-1:4];
	endfunction

	// level wanted on the bus during bit pos; 1 is recessive
	function automatic logic bit_drive(input logic [POS_W-1:0] pos, input logic own,
			input logic [FRAME_W-1:0] f, input logic [MODE_W-1:0] m);
		logic [POS_W-1:0] idx;
		idx = pos - POS_ID0;
		if (own && pos == POS_SOF) begin
			return 1'b0;
		end else if (own && pos < POS_ACK) begin
			return f[FRAME_W - 1 - int'(idx)];
		end else if (pos == POS_ACK) begin
			// own frame acked only in loopback; foreign frames never in listen-only
			return own ? !is_loopback(m) : (m == MODE_LISTEN);
		end
		return 1'b1;
	endfunction

	// register state
	logic [MODE_W-1:0] mode_ff, nxt_mode;
	logic [ID_W-1:0] mbid_ff [MB_N], nxt_mbid [MB_N];
	logic [MB_N-1:0] mben_ff, nxt_mben;
	logic rd_pend_ff, nxt_rd_pend;
	logic [APB_DW-1:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
	logic clk_en_ff, can_tx_ff;

	// engine state
	cants_eng_t eng_ff, nxt_eng;
	logic [POS_W-1:0] pos_ff, nxt_pos;
	logic [BCW-1:0] bcnt_ff, nxt_bcnt;
	logic own_ff, nxt_own, drive_ff, nxt_drive, ackerr_ff, nxt_ackerr;
	logic [FRAME_W-1:0] shr_ff, nxt_shr, rxsh_ff, nxt_rxsh;
	logic [MB_N-1:0] new_ff, nxt_new;
	logic [TS_W-1:0] ts_ff, nxt_ts;

	// glue
	logic access, clr_ackerr, smp, tx_allowed, hit;
	logic [MB_N-1:0] clr_new;
	logic [MB_AW-1:0] hit_idx, bus_idx;
	logic fifo_push, fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [FRAME_W-1:0] fifo_out_data;
	logic mem_we, mem_re;
	logic [APB_DW-1:0] mem_wdata, mem_rdata, status_word;

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign can_tx = can_tx_ff;
	assign module_clk_en = clk_en_ff;

	assign access = psel & penable & ~pready_ff;
	assign bus_idx = paddr[MB_AW+1:2];
	// queued frames wait while listen-only or asleep
	assign tx_allowed = (mode_ff != MODE_SLEEP) && (mode_ff != MODE_LISTEN);
	// wired-and with our own drive; internal loopback ignores the pin
	assign smp = (mode_ff == MODE_INTLB) ? drive_ff : (can_rx & drive_ff);
	assign status_word = APB_DW'({new_ff, ~fifo_out_valid, ~fifo_in_ready, ackerr_ff,
		eng_ff != ENG_IDLE});

	cants_fifo #(.WIDTH(FRAME_W), .DEPTH(TXQ_DEPTH)) u_txq (
		.clk(clk),
		.rst(rst),
		.in_valid(fifo_push),
		.in_data({pwdata[TX_ID_LSB+ID_W-1:TX_ID_LSB], pwdata[DATA_W-1:0]}),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	cants_mbmem #(.AW(MB_AW), .W(APB_DW)) u_mbmem (
		.clk(clk),
		.rst(rst),
		.we(mem_we),
		.waddr(hit_idx),
		.wdata(mem_wdata),
		.re(mem_re),
		.raddr(bus_idx),
		.rdata(mem_rdata)
	);

	// register port; stays live in sleep so software can wake the block
	always_comb begin
		nxt_mode = mode_ff;
		nxt_mbid = mbid_ff;
		nxt_mben = mben_ff;
		nxt_rd_pend = rd_pend_ff;
		nxt_prdata = prdata_ff;
		nxt_pready = 1'b0;
		nxt_pslverr = 1'b0;
		clr_ackerr = 1'b0;
		clr_new = '0;
		fifo_push = 1'b0;
		mem_re = 1'b0;
		if (access) begin
			nxt_pready = 1'b1;
			if (pwrite) begin
				if (paddr == OFS_MODE) begin
					if (pwdata[MODE_W-1:0] <= MODE_LISTEN) begin
						nxt_mode = pwdata[MODE_W-1:0];
					end
				end else if (paddr == OFS_STATUS) begin
					clr_ackerr = pwdata[ST_ACKERR];
				end else if (paddr == OFS_TX) begin
					// full queue stretches the access until a slot frees
					fifo_push = fifo_in_ready;
					nxt_pready = fifo_in_ready;
				end else if (in_block(paddr, OFS_MBID)) begin
					nxt_mbid[bus_idx] = pwdata[ID_W-1:0];
					nxt_mben[bus_idx] = pwdata[MB_EN_BIT];
				end else if (!in_block(paddr, OFS_MBDATA)) begin
					nxt_pslverr = 1'b1;
				end
			end else begin
				nxt_prdata = '0;
				if (paddr == OFS_MODE) begin
					nxt_prdata = APB_DW'(mode_ff);
				end else if (paddr == OFS_STATUS) begin
					nxt_prdata = status_word;
				end else if (paddr == OFS_TSTAMP) begin
					nxt_prdata = APB_DW'(ts_ff);
				end else if (in_block(paddr, OFS_MBID)) begin
					nxt_prdata = APB_DW'({mben_ff[bus_idx], 20'h00000, mbid_ff[bus_idx]});
				end else if (in_block(paddr, OFS_MBDATA)) begin
					// store is registered: one extra wait cycle
					if (!rd_pend_ff) begin
						mem_re = 1'b1;
						nxt_rd_pend = 1'b1;
						nxt_pready = 1'b0;
					end else begin
						nxt_prdata = mem_rdata;
						nxt_rd_pend = 1'b0;
						clr_new[bus_idx] = 1'b1;
					end
				end else begin
					nxt_pslverr = 1'b1;
				end
			end
		end
	end

	// bit engine
	always_comb begin
		nxt_eng = eng_ff;
		nxt_pos = pos_ff;
		nxt_bcnt = bcnt_ff;
		nxt_own = own_ff;
		nxt_shr = shr_ff;
		nxt_rxsh = rxsh_ff;
		nxt_drive = drive_ff;
		nxt_ts = ts_ff;
		// a set in the same cycle overrides these clears
		nxt_ackerr = ackerr_ff & ~clr_ackerr;
		nxt_new = new_ff & ~clr_new;
		fifo_pop = 1'b0;
		mem_we = 1'b0;
		mem_wdata = '0;
		hit = 1'b0;
		hit_idx = '0;
		// sleep freezes every engine register in place except the sticky ack error and new flags, which software can still clear
		if (mode_ff != MODE_SLEEP) begin
			nxt_ts = ts_ff + 1'b1;
			case (eng_ff)
				ENG_IDLE: begin
					nxt_drive = 1'b1;
					if (tx_allowed && fifo_out_valid) begin
						nxt_eng = ENG_FRAME;
						nxt_own = 1'b1;
						nxt_shr = fifo_out_data;
						nxt_pos = POS_SOF;
						nxt_bcnt = '0;
						nxt_drive = 1'b0;
					end else if (!smp) begin
						// start of frame seen: already one cycle into it
						nxt_eng = ENG_FRAME;
						nxt_own = 1'b0;
						nxt_pos = POS_SOF;
						nxt_bcnt = BCW'(1);
					end
				end
				ENG_FRAME: begin
					if (bcnt_ff == BIT_LAST) begin
						nxt_bcnt = '0;
						nxt_pos = pos_ff + 1'b1;
						nxt_drive = bit_drive(pos_ff + 1'b1, own_ff, shr_ff, mode_ff);
					end else begin
						nxt_bcnt = bcnt_ff + 1'b1;
					end
					if (bcnt_ff == SAMPLE_PT) begin
						if (pos_ff >= POS_ID0 && pos_ff < POS_ACK) begin
							// receive path sees own bits too in loopback
							nxt_rxsh = {rxsh_ff[FRAME_W-2:0], smp};
							if (own_ff && smp != drive_ff) begin
								nxt_own = 1'b0;
							end
						end
						if (pos_ff == POS_ACK && own_ff && smp) begin
							// self-ack in internal loopback means this never fires there
							nxt_ackerr = 1'b1;
							nxt_eng = ENG_ERROR;
							nxt_pos = POS_SOF;
							nxt_bcnt = '0;
							nxt_drive = 1'b0;
						end
						if (pos_ff == POS_LAST) begin
							nxt_eng = ENG_IDLE;
							nxt_drive = 1'b1;
							fifo_pop = own_ff;
							if (!own_ff || is_loopback(mode_ff)) begin
								for (int i = 0; i < MB_N; i++) begin
									if (!hit && mben_ff[i] &&
											mbid_ff[i] == rxsh_ff[FRAME_W-1:DATA_W]) begin
										hit = 1'b1;
										hit_idx = MB_AW'(i);
									end
								end
								mem_we = hit;
								mem_wdata = APB_DW'({ts_ff, 8'h00, rxsh_ff[DATA_W-1:0]});
								if (hit) begin
									nxt_new[hit_idx] = 1'b1;
								end
							end
						end
					end
				end
				ENG_ERROR: begin
					// only an own frame without ack gets here, never in listen-only
					nxt_drive = 1'b0;
					if (bcnt_ff == BIT_LAST) begin
						nxt_bcnt = '0;
						nxt_pos = pos_ff + 1'b1;
						if (pos_ff == ERR_LAST) begin
							nxt_eng = ENG_IDLE;
							nxt_drive = 1'b1;
						end
					end else begin
						nxt_bcnt = bcnt_ff + 1'b1;
					end
				end
				default: begin
					nxt_eng = ENG_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_ff <= MODE_RESET;
			mben_ff <= '0;
			rd_pend_ff <= 1'b0;
			prdata_ff <= '0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			clk_en_ff <= 1'b0;
			can_tx_ff <= 1'b1;
			for (int i = 0; i < MB_N; i++) begin
				mbid_ff[i] <= '0;
			end
		end else begin
			mode_ff <= nxt_mode;
			mbid_ff <= nxt_mbid;
			mben_ff <= nxt_mben;
			rd_pend_ff <= nxt_rd_pend;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			clk_en_ff <= (nxt_mode != MODE_SLEEP);
			can_tx_ff <= (nxt_mode == MODE_INTLB) ? 1'b1 : nxt_drive;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			eng_ff <= ENG_IDLE;
			pos_ff <= '0;
			bcnt_ff <= '0;
			own_ff <= 1'b0;
			shr_ff <= '0;
			rxsh_ff <= '0;
			drive_ff <= 1'b1;
			ackerr_ff <= 1'b0;
			new_ff <= '0;
			ts_ff <= '0;
		end else begin
			eng_ff <= nxt_eng;
			pos_ff <= nxt_pos;
			bcnt_ff <= nxt_bcnt;
			own_ff <= nxt_own;
			shr_ff <= nxt_shr;
			rxsh_ff <= nxt_rxsh;
			drive_ff <= nxt_drive;
			ackerr_ff <= nxt_ackerr;
			new_ff <= nxt_new;
			ts_ff <= nxt_ts;
		end
	end
endmodule

// >>> tb/cants_ctrl_asserts.sv
// port-level assertion checker for the can mode controller
module cants_chk
	import cants_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb
	input wire logic [cants_pkg::APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cants_pkg::APB_DW-1:0] pwdata,
	input wire logic pready,
	// can pin and clock gate
	input wire logic can_tx,
	input wire logic module_clk_en
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] mode_ff;
	logic mode_wr;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// true at the sample right after a mode write has landed
	assign mode_wr = pready && psel && penable && pwrite && paddr == OFS_MODE;
	// one edge behind the design; safe because modes change between frames
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_ff <= MODE_RESET;
		end else if (mode_wr && pwdata[2:0] <= MODE_LISTEN) begin
			mode_ff <= pwdata[2:0];
		end
	end
	property p_sleep_gate;
		mode_wr && pwdata[2:0] == MODE_SLEEP |-> !module_clk_en;
	endproperty
	a_sleep_gate: assert property (p_sleep_gate) else $error("clock on after sleep");
	property p_wake;
		mode_wr && pwdata[2:0] inside {[MODE_NORMAL:MODE_LISTEN]} |-> module_clk_en;
	endproperty
	a_wake: assert property (p_wake) else $error("clock off after wake");
	property p_en_cause;
		$changed(module_clk_en) |-> mode_wr;
	endproperty
	a_en_cause: assert property (p_en_cause) else $error("clock gate moved alone");
	property p_bad_code;
		mode_wr && pwdata[2:0] > MODE_LISTEN |-> $stable(module_clk_en);
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("illegal mode took effect");
	property p_intlb_quiet;
		mode_ff == MODE_INTLB |-> can_tx;
	endproperty
	a_intlb_quiet: assert property (p_intlb_quiet) else $error("pin driven in loopback");
	property p_listen_quiet;
		mode_ff == MODE_LISTEN |-> can_tx;
	endproperty
	a_listen_quiet: assert property (p_listen_quiet) else $error("pin driven listening");
	property p_frozen;
		!module_clk_en ##1 !module_clk_en |-> $stable(can_tx);
	endproperty
	a_frozen: assert property (p_frozen) else $error("pin moved while asleep");
	property p_answer;
		$rose(penable) && psel && paddr != OFS_TX && paddr[7:4] != 4'h2 |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("late register answer");
endmodule

bind cants_ctrl cants_chk u_chk (
	.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .can_tx(can_tx),
	.module_clk_en(module_clk_en)
);

// >>> tb/cants_node.sv
// behavioural far-side can node: acks the device and sends its own frames
module cants_node #(
	parameter int unsigned BC = 4
) (
	// clock
	input wire logic clk,
	// bus
	input wire logic can_tx,
	output logic can_rx,
	// behaviour
	input wire logic ack_en
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv;
	logic tx_on;
	logic slot_lvl;
	int frames;
	// wired-and line, recessive when nobody pulls it low
	assign can_rx = can_tx & drv;
	initial begin
		drv = 1'b1;
		tx_on = 1'b0;
		slot_lvl = 1'b1;
		frames = 0;
		forever begin
			@(posedge clk iff (!tx_on && can_tx === 1'b0));
			frames++;
			repeat (20 * BC - 1) @(posedge clk);
			drv <= !ack_en;
			repeat (BC / 2) @(posedge clk);
			slot_lvl = can_tx;
			repeat (BC - BC / 2) @(posedge clk);
			drv <= 1'b1;
			repeat (8 * BC) @(posedge clk);
		end
	end
	// sof, id and data, then recessive ack slot and end of frame
	task automatic send(input logic [18:0] f, output logic acked);
		logic [27:0] bits;
		bits = {1'b0, f, 8'hff};
		tx_on = 1'b1;
		acked = 1'b0;
		for (int i = 27; i >= 0; i--) begin
			drv <= bits[i];
			repeat (BC) begin
				@(posedge clk);
				if (i == 7 && can_tx === 1'b0) acked = 1'b1;
			end
		end
		tx_on = 1'b0;
	endtask
endmodule

// >>> tb/cants_ctrl_tb_top.sv
// self-checking bench for the can mode controller
module cants_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import cants_pkg::*;
	// raised bit rate keeps frames at four cycles a bit
	localparam int unsigned BR = 2_500_000;
	localparam int unsigned BC = CLK_HZ / BR;
	localparam int unsigned FR = 32 * BC;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, can_rx, can_tx, module_clk_en;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] ts;
	logic [10:0] id0;
	logic [7:0] dat;
	logic ack_en, acked;
	logic [32:0] mm;
	logic [32:0] exp_q[$], msk_q[$];
	logic [2:0] lb_mode [3] = '{MODE_INTLB, MODE_EXTLB, MODE_NORMAL};
	int err_count, total_checks, n0;
	cants_ctrl #(.BITRATE(BR)) u_cants_ctrl (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .can_rx(can_rx), .can_tx(can_tx), .module_clk_en(module_clk_en));
	cants_node #(.BC(BC)) u_cants_node (.clk(clk), .can_tx(can_tx), .can_rx(can_rx),
		.ack_en(ack_en));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// one transfer; the answer itself is judged by the monitor
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [32:0] e, input logic [32:0] m);
		int n;
		exp_q.push_back(e);
		msk_q.push_back(m);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 100) begin
			err_count++;
			final_report();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
	endtask
	task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
	endtask
	always @(posedge clk) begin
		if (pready === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(33'h0, 33'h1);
			end else begin
				mm = msk_q.pop_front();
				check({pslverr, prdata} & mm, exp_q.pop_front() & mm);
			end
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		final_report();
	end
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		ack_en = 1'b0;
		err_count = 0;
		total_checks = 0;
		void'($urandom(11729));
		id0 = 11'($urandom);
		dat = 8'($urandom);
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// asleep out of reset: gate off, counter frozen, bad codes ignored
		check({32'h0, module_clk_en}, 33'h0);
		rdx(OFS_MODE, 32'h0, 32'h7);
		rdx(OFS_STATUS, 32'h8, 32'hff);
		rdx(OFS_TSTAMP, 32'h0, 32'hffffffff);
		ts = rd[15:0];
		repeat (20) @(posedge clk);
		rdx(OFS_TSTAMP, {16'h0, ts}, 32'hffff);
		wr(OFS_MODE, 32'h5);
		rdx(OFS_MODE, 32'h0, 32'h7);
		apb(1'b1, 8'h40, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
		wr(OFS_MBID, {1'b1, 20'h0, id0});
		wr(OFS_MBID + 8'h4, {1'b1, 20'h0, ~id0});
		// own frame in both loopbacks, then normal with the far node acking
		for (int i = 0; i < 3; i++) begin
			n0 = u_cants_node.frames;
			ack_en <= (i == 2);
			wr(OFS_MODE, {29'h0, lb_mode[i]});
			// counter value just before the send bounds the captured stamp from below
			rdx(OFS_TSTAMP, 32'h0, 32'hffff0000);
			ts = rd[15:0];
			wr(OFS_TX, {13'h0, id0, dat});
			repeat (FR) @(posedge clk);
			rdx(OFS_STATUS, (i < 2) ? 32'h18 : 32'h08, 32'hff);
			check(33'(u_cants_node.frames - n0), 33'(i > 0));
			if (i == 1) check({32'h0, u_cants_node.slot_lvl}, 33'h0);
			if (i < 2) begin
				rdx(OFS_MBDATA, {24'h0, dat}, 32'hffff);
				check({32'h0, rd[31:16] > ts && rd[31:16] - ts < 16'(FR)}, 33'h1);
			end
		end
		// unacked own frame in normal raises the sticky error; loopback then completes the retry
		ack_en <= 1'b0;
		wr(OFS_TX, {13'h0, id0, dat});
		repeat (FR) @(posedge clk);
		rdx(OFS_STATUS, 32'h2, 32'h2);
		wr(OFS_MODE, {29'h0, MODE_EXTLB});
		repeat (2 * FR) @(posedge clk);
		wr(OFS_STATUS, 32'h2);
		rdx(OFS_STATUS, 32'h18, 32'hff);
		rdx(OFS_MBDATA, {24'h0, dat}, 32'hffff);
		// foreign frame: acked in normal, silent but still stored when listening
		for (int i = 0; i < 2; i++) begin
			wr(OFS_MODE, {29'h0, i ? MODE_LISTEN : MODE_NORMAL});
			u_cants_node.send({~id0, ~dat}, acked);
			check({32'h0, acked}, {32'h0, i == 0});
			repeat (8) @(posedge clk);
			rdx(OFS_STATUS, 32'h28, 32'hff);
			rdx(OFS_MBDATA + 8'h4, {24'h0, ~dat}, 32'hffff);
		end
		// queue fills while asleep, registers survive, drains on wake
		wr(OFS_MODE, {29'h0, MODE_SLEEP});
		check({32'h0, module_clk_en}, 33'h0);
		for (int i = 0; i < TXQ_DEPTH; i++) wr(OFS_TX, {13'h0, id0, 8'(i)});
		rdx(OFS_STATUS, 32'h04, 32'hff);
		rdx(OFS_MBID, {1'b1, 20'h0, id0}, 32'hffffffff);
		wr(OFS_MODE, {29'h0, MODE_INTLB});
		repeat (TXQ_DEPTH * FR) @(posedge clk);
		rdx(OFS_STATUS, 32'h18, 32'hff);
		rdx(OFS_MBDATA, {24'h0, 8'(TXQ_DEPTH - 1)}, 32'hffff);
		final_report();
	end
endmodule
